// ---- design/gfpo_defs.vh ----
`ifndef GFPO_DEFS_VH
`define GFPO_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define GFPO_A_FSEL_CLR 32'h400e0e80
`define GFPO_A_FSEL_SET 32'h400e0e84
`define GFPO_A_FSEL_STS 32'h400e0e88
`define GFPO_A_DEB_DIV 32'h400e0e8c
`define GFPO_A_PD_CLR 32'h400e0e90
`define GFPO_A_PD_SET 32'h400e0e94
`define GFPO_A_PD_STS 32'h400e0e98
`define GFPO_A_FILT_EN 32'h400e0e9c
`define GFPO_A_OW_SET 32'h400e0ea0
`define GFPO_A_OW_CLR 32'h400e0ea4
`define GFPO_A_OW_STS 32'h400e0ea8
`define GFPO_A_ODATA 32'h400e0eac
`define GFPO_A_AIM_SET 32'h400e0eb0
`define GFPO_A_AIM_CLR 32'h400e0eb4
`define GFPO_A_AIM_STS 32'h400e0eb8
`define GFPO_A_EDGE_LVL 32'h400e0ebc
`define GFPO_A_WLOCK 32'h400e0ee4
`define GFPO_A_FALL_RISE 32'h400e0ef0
`define GFPO_A_IRQ_STS 32'h400e0ef4
`define GFPO_A_IRQ_MASK 32'h400e0ef8

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define GFPO_DIV_W 14
`define GFPO_DIV_MSB 13
`define GFPO_KEY_MSB 31
`define GFPO_KEY_LSB 8
`define GFPO_KEY_VAL 24'h50494f
`define GFPO_WLOCK_BIT 0
`define GFPO_RST_WORD 32'h00000000
`define GFPO_RST_DIV 14'h0000
`define GFPO_RST_PD_EN 32'h00000000
`define GFPO_RST_OW 32'h00000000
`define GFPO_RST_ARM 2'h0

`endif

// ---- design/gfpo_div_tick.v ----
`timescale 1ns/100ps
`include "gfpo_defs.vh"

module gfpo_div_tick (
  input wire mclk,
  input wire srst,
  input wire slck,
  input wire [`GFPO_DIV_MSB:0] div,
  output reg tick
);

  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg lvl_q;
  reg [`GFPO_DIV_MSB:0] cnt_q;
  wire rise;

  // ----------------------------------------------------------------
  // Slow clock sampling
  // ----------------------------------------------------------------
  // The slow clock is asynchronous, so it is sampled as a plain level.
  always @(posedge mclk) begin
    s1_q <= slck;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // A slow clock rise counts only once the last two stages agree.
  assign rise = (s2_q == s3_q) && s3_q && !lvl_q;

  // ----------------------------------------------------------------
  // Half-period counter
  // ----------------------------------------------------------------
  // One tick every div+1 slow clock rises, half the divided period.
  always @(posedge mclk) begin
    if (srst) begin
      lvl_q <= 1'b0;
      cnt_q <= `GFPO_RST_DIV;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
      if (rise) begin
        if (cnt_q >= div) begin
          cnt_q <= `GFPO_RST_DIV;
          tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

endmodule

// ---- design/gfpo_line_filter.v ----
`timescale 1ns/100ps

module gfpo_line_filter (
  input wire mclk,
  input wire srst,
  input wire pin,
  input wire tick,
  input wire filt_en,
  input wire deb_sel,
  output wire level
);

  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg glitch_q;
  reg samp_q;
  reg deb_q;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // Three stages; the first is read by the second and nothing else.
  always @(posedge mclk) begin
    s1_q <= pin;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // ----------------------------------------------------------------
  // Glitch and debounce filters
  // ----------------------------------------------------------------
  // Sub-cycle glitches never reach two agreeing stages, so the agreed
  // level is also the glitch filter output.
  always @(posedge mclk) begin
    if (srst) begin
      glitch_q <= 1'b0;
      samp_q <= 1'b0;
      deb_q <= 1'b0;
    end else begin
      if (s2_q == s3_q) begin
        glitch_q <= s3_q;
      end
      if (tick) begin
        samp_q <= glitch_q;
        if (samp_q == glitch_q) begin
          deb_q <= glitch_q;
        end
      end
    end
  end

  // Debounce acts only while filtering is on and selected for the line; the glitch filter always acts.
  assign level = (filt_en && deb_sel) ? deb_q : glitch_q;

endmodule

// ---- design/gfpo_top.v ----
`timescale 1ns/100ps
`include "gfpo_defs.vh"

module gfpo_top (
  input wire mclk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire slck,
  input wire [31:0] line_in,
  output reg [31:0] line_out,
  output reg [31:0] pulldown_on,
  output reg irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Set/clear update of a per-line state word.
  function [31:0] setclr;
    input [31:0] cur;
    input [31:0] set;
    input [31:0] clr;
    begin
      setclr = (cur | set) & ~clr;
    end
  endfunction

  // Whether an address is one of the mapped words.
  function mapped;
    input [31:0] a;
    begin
      case (a)
        `GFPO_A_FSEL_CLR, `GFPO_A_FSEL_SET, `GFPO_A_FSEL_STS,
        `GFPO_A_DEB_DIV, `GFPO_A_PD_CLR, `GFPO_A_PD_SET,
        `GFPO_A_PD_STS, `GFPO_A_FILT_EN, `GFPO_A_OW_SET,
        `GFPO_A_OW_CLR, `GFPO_A_OW_STS, `GFPO_A_ODATA,
        `GFPO_A_AIM_SET, `GFPO_A_AIM_CLR, `GFPO_A_AIM_STS,
        `GFPO_A_EDGE_LVL, `GFPO_A_WLOCK, `GFPO_A_FALL_RISE,
        `GFPO_A_IRQ_STS, `GFPO_A_IRQ_MASK: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [31:0] fsel_q;
  reg [31:0] fsel_d;
  reg [`GFPO_DIV_MSB:0] div_q;
  reg [`GFPO_DIV_MSB:0] div_d;
  reg [31:0] pd_en_q;
  reg [31:0] pd_en_d;
  reg [31:0] filt_en_q;
  reg [31:0] filt_en_d;
  reg [31:0] ow_q;
  reg [31:0] ow_d;
  reg [31:0] odata_q;
  reg [31:0] odata_d;
  reg [31:0] aim_q;
  reg [31:0] aim_d;
  reg [31:0] edge_lvl_q;
  reg [31:0] edge_lvl_d;
  reg [31:0] fall_rise_q;
  reg [31:0] fall_rise_d;
  reg wlock_q;
  reg wlock_d;
  reg [31:0] irq_sts_q;
  reg [31:0] irq_sts_d;
  reg [31:0] irq_mask_q;
  reg [31:0] irq_mask_d;
  reg [31:0] prev_q;
  reg [31:0] rd_d;
  reg [31:0] wmask;
  reg [31:0] event_d;
  reg [1:0] arm_q;

  wire wr;
  wire tick;
  wire [31:0] level;
  wire [31:0] rise_ev;
  wire [31:0] fall_ev;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle, so no wait state is
  // ever needed and the access phase always completes at once.
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;

  // Read multiplexer over the mapped words.
  always @* begin
    case (paddr)
      `GFPO_A_FSEL_STS: rd_d = fsel_q;
      `GFPO_A_DEB_DIV: rd_d = {18'h00000, div_q};
      `GFPO_A_PD_STS: rd_d = ~pd_en_q;
      `GFPO_A_FILT_EN: rd_d = filt_en_q;
      `GFPO_A_OW_STS: rd_d = ow_q;
      `GFPO_A_ODATA: rd_d = odata_q;
      `GFPO_A_AIM_STS: rd_d = aim_q;
      `GFPO_A_EDGE_LVL: rd_d = edge_lvl_q;
      `GFPO_A_FALL_RISE: rd_d = fall_rise_q;
      `GFPO_A_WLOCK: rd_d = {31'h00000000, wlock_q};
      `GFPO_A_IRQ_STS: rd_d = irq_sts_q;
      `GFPO_A_IRQ_MASK: rd_d = irq_mask_q;
      default: rd_d = `GFPO_RST_WORD;
    endcase
  end

  // Setup-cycle capture of read data and the error answer.
  always @(posedge mclk) begin
    if (srst) begin
      prdata <= `GFPO_RST_WORD;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? `GFPO_RST_WORD : rd_d;
      pslverr <= !mapped(paddr);
    end
  end

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  // A write to a set or clear word only touches lines whose bit is
  // one; all other words keep their value.
  always @* begin
    fsel_d = fsel_q;
    div_d = div_q;
    pd_en_d = pd_en_q;
    filt_en_d = filt_en_q;
    ow_d = ow_q;
    odata_d = odata_q;
    aim_d = aim_q;
    edge_lvl_d = edge_lvl_q;
    fall_rise_d = fall_rise_q;
    wlock_d = wlock_q;
    irq_mask_d = irq_mask_q;
    wmask = `GFPO_RST_WORD;
    if (wr) begin
      case (paddr)
        `GFPO_A_FSEL_CLR: begin
          fsel_d = setclr(fsel_q, `GFPO_RST_WORD, pwdata);
        end
        `GFPO_A_FSEL_SET: begin
          fsel_d = setclr(fsel_q, pwdata, `GFPO_RST_WORD);
        end
        `GFPO_A_DEB_DIV: begin
          div_d = pwdata[`GFPO_DIV_MSB:0];
        end
        // A locked write is dropped silently, with no error answer.
        `GFPO_A_PD_CLR: begin
          if (!wlock_q) begin
            pd_en_d = setclr(pd_en_q, `GFPO_RST_WORD, pwdata);
          end
        end
        `GFPO_A_PD_SET: begin
          if (!wlock_q) begin
            pd_en_d = setclr(pd_en_q, pwdata, `GFPO_RST_WORD);
          end
        end
        `GFPO_A_FILT_EN: begin
          filt_en_d = pwdata;
        end
        `GFPO_A_OW_SET: begin
          if (!wlock_q) begin
            ow_d = setclr(ow_q, pwdata, `GFPO_RST_WORD);
          end
        end
        `GFPO_A_OW_CLR: begin
          if (!wlock_q) begin
            ow_d = setclr(ow_q, `GFPO_RST_WORD, pwdata);
          end
        end
        `GFPO_A_ODATA: begin
          // Gated lines keep their level whatever is written.
          odata_d = (odata_q & ~ow_q) | (pwdata & ow_q);
        end
        `GFPO_A_AIM_SET: begin
          aim_d = setclr(aim_q, pwdata, `GFPO_RST_WORD);
        end
        `GFPO_A_AIM_CLR: begin
          aim_d = setclr(aim_q, `GFPO_RST_WORD, pwdata);
        end
        `GFPO_A_EDGE_LVL: begin
          edge_lvl_d = pwdata;
        end
        `GFPO_A_FALL_RISE: begin
          fall_rise_d = pwdata;
        end
        `GFPO_A_WLOCK: begin
          // A wrong key aborts the write of the lock bit.
          if (pwdata[`GFPO_KEY_MSB:`GFPO_KEY_LSB] == `GFPO_KEY_VAL) begin
            wlock_d = pwdata[`GFPO_WLOCK_BIT];
          end
        end
        `GFPO_A_IRQ_STS: begin
          wmask = pwdata;
        end
        `GFPO_A_IRQ_MASK: begin
          irq_mask_d = pwdata;
        end
        default: begin
          wmask = `GFPO_RST_WORD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line filters
  // ----------------------------------------------------------------
  // One divider serves all lines, so every debounce shares one tick.
  gfpo_div_tick u_div (
    .mclk(mclk),
    .srst(srst),
    .slck(slck),
    .div(div_q),
    .tick(tick)
  );

  // One filter per line, steered straight by its register bits.
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_line
      gfpo_line_filter u_filt (
        .mclk(mclk),
        .srst(srst),
        .pin(line_in[gi]),
        .tick(tick),
        .filt_en(filt_en_q[gi]),
        .deb_sel(fsel_q[gi]),
        .level(level[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  // Edge terms shared by the default and the extra edge modes.
  assign rise_ev = level & ~prev_q;
  assign fall_ev = ~level & prev_q;

  // Default mode sees both edges; extra mode picks one edge or one
  // level. A held level raises the event on every cycle, so its
  // status bit cannot be cleared while the level stands.
  always @* begin
    event_d = (rise_ev | fall_ev) & ~aim_q;
    event_d = event_d | (aim_q & ~edge_lvl_q &
      ((rise_ev & fall_rise_q) | (fall_ev & ~fall_rise_q)));
    event_d = event_d | (aim_q & edge_lvl_q &
      ((level & fall_rise_q) | (~level & ~fall_rise_q)));
    // A new event wins over a clear in the same cycle.
    irq_sts_d = (irq_sts_q & ~wmask) |
      (event_d & {32{arm_q[1]}});
  end

  // Events stay blocked for two cycles after reset, until the filtered
  // levels and their history both hold real pin values; a pin that
  // idles high would otherwise look like a rising edge.
  always @(posedge mclk) begin
    if (srst) begin
      arm_q <= `GFPO_RST_ARM;
    end else begin
      arm_q <= {arm_q[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Software-visible state, with the history of the filtered levels.
  always @(posedge mclk) begin
    if (srst) begin
      fsel_q <= `GFPO_RST_WORD;
      div_q <= `GFPO_RST_DIV;
      pd_en_q <= `GFPO_RST_PD_EN;
      filt_en_q <= `GFPO_RST_WORD;
      ow_q <= `GFPO_RST_OW;
      odata_q <= `GFPO_RST_WORD;
      aim_q <= `GFPO_RST_WORD;
      edge_lvl_q <= `GFPO_RST_WORD;
      fall_rise_q <= `GFPO_RST_WORD;
      wlock_q <= 1'b0;
      irq_sts_q <= `GFPO_RST_WORD;
      irq_mask_q <= `GFPO_RST_WORD;
      prev_q <= `GFPO_RST_WORD;
    end else begin
      fsel_q <= fsel_d;
      div_q <= div_d;
      pd_en_q <= pd_en_d;
      filt_en_q <= filt_en_d;
      ow_q <= ow_d;
      odata_q <= odata_d;
      aim_q <= aim_d;
      edge_lvl_q <= edge_lvl_d;
      fall_rise_q <= fall_rise_d;
      wlock_q <= wlock_d;
      irq_sts_q <= irq_sts_d;
      irq_mask_q <= irq_mask_d;
      prev_q <= level;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Registered copies keep the pad controls free of decode glitches,
  // at the cost of one cycle after the register changes.
  always @(posedge mclk) begin
    if (srst) begin
      line_out <= `GFPO_RST_WORD;
      pulldown_on <= `GFPO_RST_PD_EN;
      irq <= 1'b0;
    end else begin
      line_out <= odata_q;
      pulldown_on <= pd_en_q;
      irq <= |(irq_sts_q & irq_mask_q);
    end
  end

endmodule

// ---- tb/gfpo_checker.sv ----
`timescale 1ns/100ps
`include "gfpo_defs.vh"

module gfpo_checker (
  input wire mclk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [31:0] line_out,
  input wire [31:0] pulldown_on,
  input wire irq
);
  reg lock_q;
  wire lock_wr;

  // Mirror of the lock bit; a wrong key must leave it alone.
  assign lock_wr = psel && penable && pwrite && paddr == `GFPO_A_WLOCK;
  always @(posedge mclk) begin
    if (srst)
      lock_q <= 1'h0;
    else if (lock_wr && pwdata[31:8] == `GFPO_KEY_VAL)
      lock_q <= pwdata[0];
  end

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (srst);

  // Access phase of a write and setup phase of a read.
  sequence s_wr(a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence s_rd(a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  // The pads lag the pull-down state by one clock, hence two edges.
  pd_set_a: assert property (s_wr(`GFPO_A_PD_SET) ##0 !lock_q |->
    ##2 (pulldown_on & $past(pwdata, 2)) == $past(pwdata, 2))
    else $error("pull-down set lost");
  pd_clear_a: assert property (s_wr(`GFPO_A_PD_CLR) ##0 !lock_q |->
    ##2 (pulldown_on & $past(pwdata, 2)) == 32'h0)
    else $error("pull-down clear lost");
  pd_locked_a: assert property ((s_wr(`GFPO_A_PD_SET) or
    s_wr(`GFPO_A_PD_CLR)) ##0 lock_q |-> ##2 $stable(pulldown_on))
    else $error("locked pull-down write took effect");
  pd_status_a: assert property (s_rd(`GFPO_A_PD_STS) |=>
    prdata == ~pulldown_on)
    else $error("pull-down status polarity wrong");
  div_reserved_a: assert property (s_rd(`GFPO_A_DEB_DIV) |=>
    prdata[31:14] == 18'h0)
    else $error("divider reserved bits set");
  lock_read_a: assert property (s_rd(`GFPO_A_WLOCK) |=>
    prdata == {31'h0, lock_q})
    else $error("lock word read wrong");
  write_rdata_a: assert property (psel && !penable && pwrite |=>
    prdata == 32'h0)
    else $error("read data not zero on write");
  reset_out_a: assert property ($fell(srst) |->
    !irq && line_out == 32'h0 && pulldown_on == 32'h0)
    else $error("outputs not cleared by reset");
endmodule

// ---- tb/gfpo_pad_model.sv ----
`timescale 1ns/100ps

module gfpo_pad_model (
  input wire mclk,
  input wire [31:0] drv_val,
  input wire [31:0] drv_en,
  input wire [31:0] pulldown_on,
  output wire [31:0] line_in
);
  reg [31:0] float_q = 32'h0;

  // A floating pad wanders each cycle, so nothing may rely on it.
  always @(posedge mclk)
    float_q <= ~float_q;
  // Released pads sink low only while the pull-down is on.
  assign line_in = (drv_en & drv_val) |
    (~drv_en & ~pulldown_on & float_q);
endmodule

// ---- tb/gfpo_top_tb_top.sv ----
`timescale 1ns/100ps
`include "gfpo_defs.vh"

module gfpo_top_tb_top;
  reg mclk = 1'h0, srst = 1'h1, slck = 1'h0;
  reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg [31:0] paddr = 32'h0, pwdata = 32'h0, drv_val = 32'h0;
  reg [31:0] drv_en = 32'h7fffffff, rd_q, r, e;
  reg [31:0] m [4];
  reg er_q;
  wire pready, pslverr, irq;
  wire [31:0] prdata, line_in, line_out, pulldown_on;
  int fail_count = 0, samples_checked = 0, cyc = 0, j = 0;
  // Set, clear and status words of the four per-line controls.
  logic [31:0] set_a [4] = '{`GFPO_A_FSEL_SET, `GFPO_A_PD_SET,
    `GFPO_A_OW_SET, `GFPO_A_AIM_SET};
  logic [31:0] clr_a [4] = '{`GFPO_A_FSEL_CLR, `GFPO_A_PD_CLR,
    `GFPO_A_OW_CLR, `GFPO_A_AIM_CLR};
  logic [31:0] sts_a [4] = '{`GFPO_A_FSEL_STS, `GFPO_A_PD_STS,
    `GFPO_A_OW_STS, `GFPO_A_AIM_STS};
  logic [31:0] inv [4] = '{32'h0, 32'hffffffff, 32'h0, 32'h0};

  gfpo_top gfpo_top_i (.mclk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .slck, .line_in, .line_out,
    .pulldown_on, .irq);
  gfpo_pad_model gfpo_pad_model_i (.mclk, .drv_val, .drv_en,
    .pulldown_on, .line_in);

  // Slow clock has no phase relation to the main clock.
  always #12.5 mclk = ~mclk;
  always #123.1 slck = ~slck;

  // Hang guard.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      test_done;
    end
  end

  task automatic test_done;
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input [31:0] x, input [31:0] s);
    samples_checked = samples_checked + 1;
    if (s !== x) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask

  // Expected word after a write that sets some lines and clears others.
  function automatic [31:0] upd(input [31:0] cur, input [31:0] s,
    input [31:0] c);
    return (cur | s) & ~c;
  endfunction

  // One APB transfer; data and error are taken at the ready edge.
  task automatic apb(input w, input [31:0] a, input [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd_q = prdata;
    er_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Move line 0, wait, then look at the interrupt and clear status.
  task automatic line_irq(input v, input x, input int w);
    drv_val[0] <= v;
    repeat (w) @(posedge mclk);
    @(negedge mclk);
    chk("irq", {31'h0, x}, {31'h0, irq});
    apb(1, `GFPO_A_IRQ_STS, 32'hffffffff);
  endtask

  initial begin
    r = $urandom(59223);
    repeat (3) @(posedge mclk);
    srst <= 1'h0;
    for (int k = 0; k < 4; k++) begin
      m[k] = 32'h0;
      apb(0, sts_a[k], 32'h0);
      chk("status at reset", inv[k], rd_q);
    end
    // Random set and clear masks on every control, then read back.
    for (int i = 0; i < 16; i++) begin
      j = i % 4;
      r = $urandom;
      apb(1, set_a[j], r);
      m[j] = upd(m[j], r, 32'h0);
      r = $urandom;
      apb(1, clr_a[j], r);
      m[j] = upd(m[j], 32'h0, r);
      apb(0, sts_a[j], 32'h0);
      chk("status", m[j] ^ inv[j], rd_q);
    end
    chk("pull-down pins", m[1], pulldown_on);
    r = $urandom;
    apb(1, `GFPO_A_DEB_DIV, r);
    apb(0, `GFPO_A_DEB_DIV, 32'h0);
    chk("divider", r & 32'h3fff, rd_q);
    // Lock with a wrong key, then the right one; gated writes are lost.
    apb(1, `GFPO_A_WLOCK, {~`GFPO_KEY_VAL, 8'h01});
    apb(0, `GFPO_A_WLOCK, 32'h0);
    chk("lock bad key", 32'h0, rd_q);
    apb(1, `GFPO_A_WLOCK, {`GFPO_KEY_VAL, 8'h01});
    apb(1, `GFPO_A_PD_SET, ~m[1]);
    apb(1, `GFPO_A_OW_CLR, m[2]);
    apb(0, `GFPO_A_PD_STS, 32'h0);
    chk("locked pull-down", ~m[1], rd_q);
    apb(0, `GFPO_A_OW_STS, 32'h0);
    chk("locked gate", m[2], rd_q);
    apb(1, `GFPO_A_WLOCK, {`GFPO_KEY_VAL, 8'h00});
    // Data writes reach only the lines whose gate is open.
    e = 32'h0;
    repeat (2) begin
      r = $urandom;
      apb(1, `GFPO_A_ODATA, r);
      e = upd(e & ~m[2], r & m[2], 32'h0);
      apb(0, `GFPO_A_ODATA, 32'h0);
      chk("output data", e, rd_q);
      chk("line out", e, line_out);
    end
    apb(0, 32'h400e0f00, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er_q});
    // Default mode, then rising edge, then low level, then masked.
    apb(1, `GFPO_A_IRQ_MASK, 32'h1);
    apb(1, `GFPO_A_AIM_CLR, 32'h1);
    apb(1, `GFPO_A_IRQ_STS, 32'hffffffff);
    line_irq(1, 1, 8);
    line_irq(0, 1, 8);
    apb(1, `GFPO_A_AIM_SET, 32'h1);
    apb(1, `GFPO_A_FALL_RISE, 32'h1);
    apb(1, `GFPO_A_EDGE_LVL, 32'h0);
    apb(1, `GFPO_A_IRQ_STS, 32'hffffffff);
    line_irq(1, 1, 8);
    line_irq(0, 0, 8);
    apb(1, `GFPO_A_FALL_RISE, 32'h0);
    apb(1, `GFPO_A_EDGE_LVL, 32'h1);
    line_irq(0, 1, 8);
    apb(1, `GFPO_A_IRQ_MASK, 32'h0);
    line_irq(0, 0, 8);
    // Debounce drops a short pulse and passes a long level.
    apb(1, `GFPO_A_AIM_CLR, 32'h1);
    apb(1, `GFPO_A_IRQ_MASK, 32'h1);
    apb(1, `GFPO_A_FILT_EN, 32'h1);
    apb(1, `GFPO_A_FSEL_SET, 32'h1);
    apb(1, `GFPO_A_DEB_DIV, 32'h3);
    apb(1, `GFPO_A_IRQ_STS, 32'hffffffff);
    drv_val[0] <= 1'h1;
    repeat (4) @(posedge mclk);
    line_irq(0, 0, 300);
    line_irq(1, 1, 300);
    apb(1, `GFPO_A_FSEL_CLR, 32'h1);
    line_irq(0, 1, 8);
    test_done;
  end
endmodule

bind gfpo_top gfpo_checker gfpo_checker_i (.mclk, .srst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .line_out, .pulldown_on,
  .irq);
